// >>> bench/test_watchdog_two_stage_timeout.sv
// Purpose: directed bench for the two-stage watchdog
// Assumes: strobes driven by nonblocking assignment at rising edges
// Notes: one data bus feeds all write ports
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_two_stage_timeout;
   logic        core_clk     = 1'b0;
   logic        resetn       = 1'b0;
   logic [3:0]  we           = 4'h0;
   logic [31:0] wd           = 32'h0000_0000;
   logic        stall_enable = 1'b0;
   logic        cpu_halted   = 1'b0;
   logic [31:0] reload, count, snap;
   logic [1:0]  ctl;
   logic        raw, masked, locked, irq, rst_out;
   int          fail_count   = 0;
   int          cmp_count    = 0;
   int          cyc          = 0;
   wdt_top DUT (.core_clk(core_clk), .resetn(resetn), .timeout_reload_value_we(we[0]),
      .timeout_reload_value_wdata(wd), .timeout_control_we(we[1]),
      .timeout_control_wdata(wd[1:0]), .timeout_interrupt_clear_we(we[2]),
      .config_lock_key_we(we[3]), .config_lock_key_wdata(wd), .stall_enable(stall_enable),
      .cpu_halted(cpu_halted), .timeout_reload_value(reload), .count_value(count),
      .timeout_control(ctl), .raw_timeout_status(raw), .masked_timeout_status(masked),
      .locked(locked), .timeout_irq(irq), .system_reset_out(rst_out));
   always #4 core_clk = ~core_clk;
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         fail_count++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic put(input int k, input logic [31:0] d);
      @(posedge core_clk);
      we[k] <= 1'b1;
      wd    <= d;
      @(posedge core_clk);
      we[k] <= 1'b0;
      #1;
   endtask : put
   task automatic wt(input int n, input logic s);
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         if ((s ? rst_out : raw) === 1'b1)
            break;
      end
   endtask : wt
   task automatic hw_reset();
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
   endtask : hw_reset
   initial
   begin
      hw_reset();
      chk(count, 32'hffff_ffff);
      chk(reload, wdt_pkg::RELOAD_RESET_VALUE);
      chk({ctl, raw, locked, rst_out}, 32'h0000_0000);
      $display("test reset values done");
      put(0, 32'h0000_000a);
      chk(count, 32'h0000_000a);
      put(1, 32'h0000_0002);
      put(1, 32'h0000_0003);
      chk(ctl, 32'h0000_0003);
      put(1, 32'h0000_0000);
      chk(ctl, 32'h0000_0003);
      wt(30, 1'b0);
      chk(count, 32'h0000_000a);
      chk(irq, 32'h0000_0001);
      put(0, 32'h0000_000c);
      chk(raw, 32'h0000_0001);
      put(2, 32'h0000_0000);
      chk(raw, 32'h0000_0000);
      chk(count, 32'h0000_000c);
      wt(30, 1'b0);
      wt(30, 1'b1);
      chk(rst_out, 32'h0000_0001);
      $display("test two stage done");
      hw_reset();
      chk({ctl, raw, locked, rst_out}, 32'h0000_0000);
      put(3, 32'h0000_0005);
      chk(locked, 32'h0000_0001);
      put(0, 32'h0000_0007);
      chk(reload, wdt_pkg::RELOAD_RESET_VALUE);
      put(3, wdt_pkg::UNLOCK_KEY);
      chk(locked, 32'h0000_0000);
      put(0, 32'h0000_0014);
      put(1, 32'h0000_0001);
      chk(count, 32'h0000_0014);
      @(posedge core_clk);
      stall_enable <= 1'b1;
      cpu_halted   <= 1'b1;
      @(posedge core_clk);
      #1;
      snap = count;
      chk(snap, 32'h0000_0013);
      repeat (4) @(posedge core_clk);
      #1;
      chk(count, snap);
      @(posedge core_clk);
      cpu_halted <= 1'b0;
      wt(40, 1'b0);
      chk(masked, 32'h0000_0001);
      repeat (25) @(posedge core_clk);
      #1;
      chk(rst_out, 32'h0000_0000);
      put(2, 32'h0000_0000);
      put(0, 32'h0000_0000);
      wt(3, 1'b0);
      chk(raw, 32'h0000_0001);
      $display("test lock stall done");
      complete_run();
   end
endmodule : test_watchdog_two_stage_timeout
`default_nettype wire

// >>> bench/wdt_top_sva.sv
// Purpose: port checker for the two-stage watchdog
// Assumes: bound to wdt_top, one clock domain
// Notes: counts handled with plain relations
`timescale 1ns/1ps
`default_nettype none
module wdt_top_chk
   import wdt_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        timeout_reload_value_we,
   input wire logic [31:0] timeout_reload_value_wdata,
   input wire logic        timeout_interrupt_clear_we,
   input wire logic        config_lock_key_we,
   input wire logic [31:0] config_lock_key_wdata,
   input wire logic        stall_enable,
   input wire logic        cpu_halted,
   input wire logic [31:0] count_value,
   input wire logic [1:0]  timeout_control,
   input wire logic        raw_timeout_status,
   input wire logic        masked_timeout_status,
   input wire logic        locked,
   input wire logic        timeout_irq,
   input wire logic        system_reset_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic hold_w = stall_enable & cpu_halted;
   wire logic run_w  = timeout_control[0] & !hold_w & !timeout_reload_value_we;
   a_masked_and: assert property (masked_timeout_status == (raw_timeout_status & timeout_control[0]))
      else $error("masked status wrong");
   a_clear_drops: assert property (!locked && timeout_interrupt_clear_we && raw_timeout_status
      |=> !raw_timeout_status) else $error("clear ignored");
   a_key_unlocks: assert property (config_lock_key_we && config_lock_key_wdata == UNLOCK_KEY
      |=> !locked) else $error("key did not unlock");
   a_any_locks: assert property (config_lock_key_we && config_lock_key_wdata != UNLOCK_KEY
      |=> locked) else $error("lock write did not lock");
   a_ctl_frozen: assert property (timeout_control[0] |=> $stable(timeout_control))
      else $error("control changed after enable");
   a_reload_loads: assert property (!locked && timeout_reload_value_we
      |=> count_value == $past(timeout_reload_value_wdata)) else $error("reload not loaded");
   a_dec_one: assert property (run_w && !timeout_interrupt_clear_we && count_value > 32'h0000_0001
      |=> count_value == $past(count_value) - 32'h0000_0001) else $error("bad decrement");
   a_stall_holds: assert property (hold_w && timeout_control[0] && !timeout_reload_value_we
      && !timeout_interrupt_clear_we |=> $stable(count_value)) else $error("count moved in stall");
   a_first_zero: assert property (run_w && count_value == 32'h0 && $past(count_value) == 32'h1
      |=> raw_timeout_status) else $error("no time-out at zero");
   a_irq_follows: assert property (timeout_irq == masked_timeout_status)
      else $error("irq differs from masked status");
   a_reset_sticky: assert property (system_reset_out |=> system_reset_out)
      else $error("reset output dropped");
   a_reset_needs_en: assert property ($rose(system_reset_out) |-> timeout_control[1])
      else $error("reset without enable");
endmodule : wdt_top_chk
bind wdt_top wdt_top_chk u_chk (.core_clk, .resetn, .timeout_reload_value_we,
   .timeout_reload_value_wdata, .timeout_interrupt_clear_we, .config_lock_key_we,
   .config_lock_key_wdata, .stall_enable, .cpu_halted, .count_value, .timeout_control,
   .raw_timeout_status, .masked_timeout_status, .locked, .timeout_irq, .system_reset_out);
`default_nettype wire

// >>> design/wdt_cnt_if.sv
// Purpose: carrier between the watchdog control and its down counter
// Assumes: all signals in the core_clk domain
// Notes: load has priority over decrement
`timescale 1ns/1ps
`default_nettype none
interface wdt_cnt_if;
   logic        load;
   logic [31:0] load_value;
   logic        dec_en;
   logic [31:0] count;
   logic        at_zero;
   modport ctrl (output load, output load_value, output dec_en, input count, input at_zero);
   modport cnt  (input load, input load_value, input dec_en, output count, output at_zero);
endinterface : wdt_cnt_if
`default_nettype wire

// >>> design/wdt_counter.sv
// Purpose: down counter with load, hold and zero flag
// Assumes: load wins over decrement
// Notes: stops at zero until reloaded
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
   import wdt_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   wdt_cnt_if.cnt    cif
);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;

   always_comb
   begin
      count_d = count_q;
      if (cif.load)
      begin
         count_d = cif.load_value;
      end
      else if (cif.dec_en && (count_q != COUNT_ZERO))
      begin
         count_d = count_q - 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         count_q <= RELOAD_RESET_VALUE;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   assign cif.count   = count_q;
   assign cif.at_zero = (count_q == COUNT_ZERO);
endmodule : wdt_counter
`default_nettype wire

// >>> design/wdt_pkg.sv
// Purpose: shared constants and types for the two-stage watchdog
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes: no register bus; software accesses arrive as write strobes
package wdt_pkg;
   localparam int unsigned CNT_W                       = 32;
   localparam logic [31:0] RELOAD_RESET_VALUE          = 32'hffff_ffff;
   localparam logic [31:0] UNLOCK_KEY                  = 32'h1acc_e551;
   localparam logic [31:0] COUNT_ZERO                  = 32'h0000_0000;
   localparam int unsigned CTL_INT_EN_BIT              = 0;
   localparam int unsigned CTL_RST_EN_BIT              = 1;
   localparam logic [1:0]  CTL_RESET_VALUE             = 2'h0;

   typedef enum logic [1:0] {
      WDT_ST_IDLE,
      WDT_ST_RUN,
      WDT_ST_RESET
   } wdt_state_t;
endpackage : wdt_pkg

// >>> design/wdt_top.sv
// Purpose: two-stage watchdog, interrupt on first time-out, reset on second
// Assumes: write strobes are one-cycle pulses synchronous to core_clk
// Notes: control and lock accesses are plain ports, no bus decode
`timescale 1ns/1ps
`default_nettype none
module wdt_top
   import wdt_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         timeout_reload_value_we,
   input  wire logic [31:0]  timeout_reload_value_wdata,
   input  wire logic         timeout_control_we,
   input  wire logic [1:0]   timeout_control_wdata,
   input  wire logic         timeout_interrupt_clear_we,
   input  wire logic         config_lock_key_we,
   input  wire logic [31:0]  config_lock_key_wdata,
   input  wire logic         stall_enable,
   input  wire logic         cpu_halted,
   output logic [31:0]       timeout_reload_value,
   output logic [31:0]       count_value,
   output logic [1:0]        timeout_control,
   output logic              raw_timeout_status,
   output logic              masked_timeout_status,
   output logic              locked,
   output logic              timeout_irq,
   output logic              system_reset_out
);
   wdt_cnt_if cif ();

   logic [31:0] reload_q;
   logic [31:0] reload_d;
   logic        int_en_q;
   logic        int_en_d;
   logic        rst_en_q;
   logic        rst_en_d;
   logic        lock_q;
   logic        lock_d;
   logic        ris_q;
   logic        ris_d;
   logic        rst_q;
   logic        rst_d;
   logic        zero_seen_q;
   logic        zero_seen_d;
   wdt_state_t  state_q;
   wdt_state_t  state_d;

   logic reload_wr_ok;
   logic ctl_wr_ok;
   logic clr_wr_ok;
   logic timeout_evt;
   logic stalled;

   assign reload_wr_ok = timeout_reload_value_we && !lock_q;
   assign ctl_wr_ok    = timeout_control_we && !lock_q && !int_en_q;
   assign clr_wr_ok    = timeout_interrupt_clear_we && !lock_q;
   assign stalled      = stall_enable && cpu_halted;
   // one event per arrival at zero
   assign timeout_evt  = (state_q == WDT_ST_RUN) && cif.at_zero && !zero_seen_q;

   always_comb
   begin
      reload_d    = reload_q;
      int_en_d    = int_en_q;
      rst_en_d    = rst_en_q;
      lock_d      = lock_q;
      ris_d       = ris_q;
      rst_d       = rst_q;
      zero_seen_d = zero_seen_q;
      state_d     = state_q;
      cif.load       = 1'b0;
      cif.load_value = reload_q;
      cif.dec_en     = (state_q == WDT_ST_RUN) && !stalled;

      if (config_lock_key_we)
      begin
         lock_d = (config_lock_key_wdata != UNLOCK_KEY);
      end

      if (reload_wr_ok)
      begin
         reload_d       = timeout_reload_value_wdata;
         cif.load       = 1'b1;
         cif.load_value = timeout_reload_value_wdata;
         zero_seen_d    = 1'b0;
      end

      if (ctl_wr_ok)
      begin
         rst_en_d = timeout_control_wdata[CTL_RST_EN_BIT];
         int_en_d = timeout_control_wdata[CTL_INT_EN_BIT];
         if (timeout_control_wdata[CTL_INT_EN_BIT])
         begin
            state_d = WDT_ST_RUN;
            if (!reload_wr_ok)
            begin
               cif.load    = 1'b1;
               zero_seen_d = 1'b0;
            end
         end
      end

      case (state_q)
         WDT_ST_IDLE:
         begin
         end
         WDT_ST_RUN:
         begin
            if (timeout_evt && !reload_wr_ok)
            begin
               if (ris_q && !clr_wr_ok && rst_en_q)
               begin
                  rst_d   = 1'b1;
                  state_d = WDT_ST_RESET;
               end
               else
               begin
                  ris_d = 1'b1;
                  if (reload_q == COUNT_ZERO)
                  begin
                     zero_seen_d = 1'b1;
                  end
                  else
                  begin
                     cif.load = 1'b1;
                  end
               end
            end
         end
         WDT_ST_RESET:
         begin
            rst_d = 1'b1;
         end
         default:
         begin
            state_d = WDT_ST_IDLE;
         end
      endcase

      // clear loses to a same-cycle time-out only while raw status is low; a clear wins over a repeat time-out
      if (clr_wr_ok && !(timeout_evt && !ris_q))
      begin
         ris_d = 1'b0;
         if (!reload_wr_ok && (state_q == WDT_ST_RUN))
         begin
            cif.load    = 1'b1;
            zero_seen_d = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         reload_q    <= RELOAD_RESET_VALUE;
         int_en_q    <= CTL_RESET_VALUE[CTL_INT_EN_BIT];
         rst_en_q    <= CTL_RESET_VALUE[CTL_RST_EN_BIT];
         lock_q      <= 1'b0;
         ris_q       <= 1'b0;
         rst_q       <= 1'b0;
         zero_seen_q <= 1'b0;
         state_q     <= WDT_ST_IDLE;
      end
      else
      begin
         reload_q    <= reload_d;
         int_en_q    <= int_en_d;
         rst_en_q    <= rst_en_d;
         lock_q      <= lock_d;
         ris_q       <= ris_d;
         rst_q       <= rst_d;
         zero_seen_q <= zero_seen_d;
         state_q     <= state_d;
      end
   end

   wdt_counter u_counter (
      .core_clk (core_clk),
      .resetn   (resetn),
      .cif      (cif)
   );

   assign timeout_reload_value  = reload_q;
   assign count_value           = cif.count;
   assign timeout_control       = {rst_en_q, int_en_q};
   assign raw_timeout_status    = ris_q;
   assign masked_timeout_status = ris_q && int_en_q;
   assign timeout_irq           = ris_q && int_en_q;
   assign locked                = lock_q;
   assign system_reset_out      = rst_q;
endmodule : wdt_top
`default_nettype wire
